//--- src/dhc_top.sv
// Dual H-bridge chopping control with AXI4-Lite status and control registers
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: Bridge inputs 00 coast, 01 L/H, 10 H/L, 11 both low.
// R2: Controller makes speed PWM by toggling one input; the toggled input sets direction.
// R3: On threshold stop driving, decay until next PWM cycle, then drive again.
// R4: Sense times five compared with scaled reference; scale code goes to comparator.
// R5: Scale code 00 is 100, 01 is 71, 10 is 38 percent.
// R6: Scale code 11 disables that bridge regardless of inputs.
// R7: Fast decay reverses drive, then coasts as current nears zero.
// R8: Slow decay turns both low sides on for rest of cycle.
// R9: Decay select low slow, open mixed, high fast, shared by bridges.
// R10: Mixed decay starts fast, becomes slow at 75 percent of cycle.
// R11: Threshold ignored for 3.75 us after current is enabled.
// R12: Reset input low holds logic in reset and bridges off.
// R13: Sleep low disables bridges, pump, regulator and clocks; inputs ignored.
// R14: About 1 ms after leaving sleep before drive is usable.
// R15: Controller drives reset and sleep inputs high for operation.
// R16: Current limit persisting past overcurrent time latches bridge off, fault low.
// R17: Overcurrent detect uses its own limit flags, not the chopping sense.
// R18: Over-temperature disables switches, fault low, resumes when it clears.
// R19: Undervoltage resets logic and disables everything until supply returns.
// R20: Chopping cycle runs at 50 kHz for both bridges.
// R21: Overcurrent time is a parameter in clock cycles from limit assertion.
module dhc_top
  import dhc_pkg::*;
#(
  parameter int unsigned WAKE_CNT = WAKE_CYC,
  parameter int unsigned OVC_CNT  = 100
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bridge_a_in_one,
  input  wire logic        bridge_a_in_two,
  input  wire logic        bridge_b_in_one,
  input  wire logic        bridge_b_in_two,
  input  wire logic        bridge_a_scale_lsb,
  input  wire logic        bridge_a_scale_msb,
  input  wire logic        bridge_b_scale_lsb,
  input  wire logic        bridge_b_scale_msb,
  input  wire logic        sense_node_a_trip,
  input  wire logic        sense_node_b_trip,
  input  wire logic        sense_node_a_zero,
  input  wire logic        sense_node_b_zero,
  input  wire logic        current_limit_a,
  input  wire logic        current_limit_b,
  input  wire logic        reset_low_input,
  input  wire logic        sleep_low_input,
  input  wire logic        decay_select_high,
  input  wire logic        decay_select_low,
  input  wire logic        thermal_shutdown_in,
  input  wire logic        undervoltage_lockout_in,
  output logic             bridge_a_out_one_hi,
  output logic             bridge_a_out_one_lo,
  output logic             bridge_a_out_two_hi,
  output logic             bridge_a_out_two_lo,
  output logic             bridge_b_out_one_hi,
  output logic             bridge_b_out_one_lo,
  output logic             bridge_b_out_two_hi,
  output logic             bridge_b_out_two_lo,
  output logic [1:0]       current_reference_a_sel,
  output logic [1:0]       current_reference_b_sel,
  output logic             charge_pump_en,
  output logic             regulator_output_en,
  output logic             fault_flag_low_o,
  output logic             fault_flag_low_oe
);
  if (WAKE_CNT < 1 || WAKE_CNT >= (1 << 24)) $error("WAKE_CNT out of range");
  if (OVC_CNT < 1 || OVC_CNT >= (1 << CNT_W)) $error("OVC_CNT out of range");

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_m_r;
  logic [PIN_W-1:0] pin_r;
  assign pin_raw = {undervoltage_lockout_in, thermal_shutdown_in, decay_select_low,
                    decay_select_high, sleep_low_input, reset_low_input,
                    current_limit_b, current_limit_a, sense_node_b_zero, sense_node_a_zero,
                    sense_node_b_trip, sense_node_a_trip, bridge_b_scale_msb,
                    bridge_a_scale_msb, bridge_b_scale_lsb, bridge_a_scale_lsb,
                    bridge_b_in_two, bridge_a_in_two, bridge_b_in_one, bridge_a_in_one};
  // Two flops on every pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_r <= '0;
      pin_r   <= '0;
    end else begin
      pin_m_r <= pin_raw;
      pin_r   <= pin_m_r;
    end
  end

  // ****************************************
  // Device state: reset, sleep, wake-up
  // ****************************************
  logic        soft_rst;
  logic        asleep;
  logic        run;
  logic        awake;
  logic        otemp;
  logic [23:0] wake_r;
  logic [31:0] ctrl_r;
  dhc_decay_e  decay_mode;
  assign soft_rst = !pin_r[P_RSTL] || pin_r[P_UV];  // R12 R19
  assign asleep   = !pin_r[P_SLPL];
  assign run      = !soft_rst && !asleep;  // R13
  assign awake    = (wake_r == 24'h00_0000);
  assign otemp    = pin_r[P_OTMP];
  // Wake-up delay reloaded while asleep or supply low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_r <= 24'(WAKE_CNT);
    end else if (asleep || pin_r[P_UV]) begin
      wake_r <= 24'(WAKE_CNT);  // R14
    end else if (!awake) begin
      wake_r <= wake_r - 24'h00_0001;
    end
  end
  // Three-level decay select, open reads as mixed
  always_comb begin
    if (pin_r[P_DHI] && !pin_r[P_DLO]) decay_mode = DM_FAST;  // R9
    else if (pin_r[P_DLO] && !pin_r[P_DHI]) decay_mode = DM_SLOW;
    else decay_mode = DM_MIXED;
  end

  // ****************************************
  // Fixed-frequency chopping period
  // ****************************************
  logic [CNT_W-1:0] per_r;
  logic             cyc_start;
  logic             mix_point;
  assign cyc_start = run && (per_r == CNT_W'(CHOP_CYC - 1));
  assign mix_point = (per_r >= CNT_W'(MIX_CYC));
  // Period counter stops while asleep or in reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      per_r <= '0;
    end else if (cyc_start) begin
      per_r <= '0;  // R20
    end else begin
      per_r <= per_r + CNT_W'(1);
    end
  end

  // ****************************************
  // Per-bridge chopping, decode and protection
  // ****************************************
  logic [1:0] ovc_r;
  logic [1:0] in_decay;
  logic [3:0] drv_r [2];  // {one_hi, one_lo, two_hi, two_lo}
  for (genvar b = 0; b < 2; b++) begin : g_br
    logic             in1;
    logic             in2;
    logic [1:0]       scale;
    logic             driving;
    logic             drv_prev_r;
    logic             off;
    logic [CNT_W-1:0] blank_r;
    logic [CNT_W-1:0] ovc_cnt_r;
    logic [3:0]       drv_nxt;
    dhc_chop_e        st_r;
    assign in1     = pin_r[P_IN1 + b];
    assign in2     = pin_r[P_IN2 + b];
    assign scale   = {pin_r[P_SMSB + b], pin_r[P_SLSB + b]};
    assign driving = in1 ^ in2;
    assign off     = !run || !awake || ovc_r[b] || otemp || (scale == SCALE_OFF)
                     || ctrl_r[CTRL_COAST];  // R6 R16 R18
    assign in_decay[b] = (st_r != CH_DRIVE);
    // Blanking restarts each time drive current is enabled
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        drv_prev_r <= 1'b0;
        blank_r    <= CNT_W'(BLANK_CYC);
      end else begin
        drv_prev_r <= driving && !in_decay[b];
        if ((driving && !drv_prev_r) || cyc_start) blank_r <= CNT_W'(BLANK_CYC);  // R11
        else if (blank_r != '0) blank_r <= blank_r - CNT_W'(1);
      end
    end
    // Chopping state per bridge
    always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
        st_r <= CH_DRIVE;
      end else if (!driving || cyc_start) begin
        st_r <= CH_DRIVE;  // R3
      end else begin
        case (st_r)
          CH_DRIVE: begin
            if (ctrl_r[CTRL_CHOP] && blank_r == '0 && pin_r[P_TRIP + b]) begin  // R3 R11
              st_r <= (decay_mode == DM_SLOW) ? CH_SLOW : CH_FAST;
            end
          end
          CH_FAST: begin
            if (decay_mode == DM_MIXED && mix_point) st_r <= CH_SLOW;  // R10
            else if (pin_r[P_ZERO + b]) st_r <= CH_IDLE;  // R7
          end
          CH_IDLE: begin
            if (decay_mode == DM_MIXED && mix_point) st_r <= CH_SLOW;  // R10
          end
          CH_SLOW: st_r <= CH_SLOW;  // R8
          default: st_r <= CH_DRIVE;
        endcase
      end
    end
    // Output decode of inputs and chopping state
    always_comb begin
      case ({in1, in2})
        2'b01:   drv_nxt = 4'b0110;  // R1
        2'b10:   drv_nxt = 4'b1001;
        2'b11:   drv_nxt = 4'b0101;
        default: drv_nxt = 4'b0000;
      endcase
      if (driving) begin
        case (st_r)
          CH_FAST: drv_nxt = {drv_nxt[1:0], drv_nxt[3:2]};  // R7
          CH_SLOW: drv_nxt = 4'b0101;  // R8
          CH_IDLE: drv_nxt = 4'b0000;
          default: drv_nxt = drv_nxt;
        endcase
      end
      if (off) drv_nxt = 4'b0000;  // R12 R13 R19
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) drv_r[b] <= 4'b0000;
      else drv_r[b] <= drv_nxt;
    end
    // Overcurrent: own limit flag, latched, cleared only by logic reset
    always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
        ovc_cnt_r <= '0;
        ovc_r[b]  <= 1'b0;
      end else if (!pin_r[P_ILIM + b] || asleep) begin
        ovc_cnt_r <= '0;  // R17
      end else if (ovc_cnt_r == CNT_W'(OVC_CNT)) begin
        ovc_r[b]  <= 1'b1;  // R16 R21
      end else begin
        ovc_cnt_r <= ovc_cnt_r + CNT_W'(1);
      end
    end
  end

  // Scale code handed to the comparator reference divider
  assign current_reference_a_sel = {pin_r[P_SMSB], pin_r[P_SLSB]};  // R4 R5
  assign current_reference_b_sel = {pin_r[P_SMSB + 1], pin_r[P_SLSB + 1]};
  assign {bridge_a_out_one_hi, bridge_a_out_one_lo,
          bridge_a_out_two_hi, bridge_a_out_two_lo} = drv_r[0];
  assign {bridge_b_out_one_hi, bridge_b_out_one_lo,
          bridge_b_out_two_hi, bridge_b_out_two_lo} = drv_r[1];
  assign fault_flag_low_o = 1'b0;  // Open drain only pulls low

  // ****************************************
  // Supply enables and fault flag
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_pump_en      <= 1'b0;
      regulator_output_en <= 1'b0;
      fault_flag_low_oe   <= 1'b0;
    end else begin
      charge_pump_en      <= !asleep && !pin_r[P_UV];  // R13 R19
      regulator_output_en <= !asleep && !pin_r[P_UV];
      fault_flag_low_oe   <= (|ovc_r) || otemp;  // R16 R18
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [31:0] stat;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign stat = {22'h00_0000, in_decay, decay_mode, awake, pin_r[P_UV], otemp, ovc_r};
  // Write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= '0;
      wstrb_r      <= '0;
      ctrl_r       <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[11:2] == REG_CTRL[11:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (wstrb_r[0]) ctrl_r[1:0] <= wdata_r[1:0];
        end else if (awaddr_r[11:2] == REG_STAT[11:2] || awaddr_r[11:2] == REG_DRIVE[11:2]) begin
          s_axi_bresp <= RESP_OKAY;  // Read-only, write ignored
        end else begin
          s_axi_bresp <= RESP_SLV;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read channel: one cycle after address accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr[11:2])
        REG_CTRL[11:2]:  s_axi_rdata <= ctrl_r;
        REG_STAT[11:2]:  s_axi_rdata <= stat;
        REG_DRIVE[11:2]: s_axi_rdata <= {24'h00_0000, drv_r[1], drv_r[0]};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLV;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : dhc_top
`default_nettype wire

//--- pkg/dhc_pkg.sv
// Constants, register map and state types of the dual H-bridge chopping control
package dhc_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam real         CLK_NS     = 20.0;
  localparam int unsigned CHOP_KHZ   = 50;
  localparam int unsigned CHOP_CYC   = CLK_HZ / (CHOP_KHZ * 1000);
  localparam int unsigned MIX_PCT    = 75;
  localparam int unsigned MIX_CYC    = CHOP_CYC * MIX_PCT / 100;
  localparam real         BLANK_US   = 3.75;
  localparam int unsigned BLANK_CYC  = int'($ceil(BLANK_US * 1000.0 / CLK_NS));
  localparam int unsigned WAKE_MS    = 1;
  localparam int unsigned WAKE_CYC   = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W      = 16;
  // ****************************************
  // Pin vector positions after the synchroniser
  // ****************************************
  localparam int unsigned P_IN1   = 0;  // Bridge inputs one, bits 0..1
  localparam int unsigned P_IN2   = 2;
  localparam int unsigned P_SLSB  = 4;
  localparam int unsigned P_SMSB  = 6;
  localparam int unsigned P_TRIP  = 8;
  localparam int unsigned P_ZERO  = 10;
  localparam int unsigned P_ILIM  = 12;
  localparam int unsigned P_RSTL  = 14;
  localparam int unsigned P_SLPL  = 15;
  localparam int unsigned P_DHI   = 16;
  localparam int unsigned P_DLO   = 17;
  localparam int unsigned P_OTMP  = 18;
  localparam int unsigned P_UV    = 19;
  localparam int unsigned PIN_W   = 20;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STAT   = 12'h004;
  localparam logic [11:0] REG_DRIVE  = 12'h008;
  localparam int unsigned CTRL_CHOP  = 0;  // Current regulation on
  localparam int unsigned CTRL_COAST = 1;  // Software coast of both bridges
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam logic [1:0]  SCALE_OFF  = 2'h3;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    CH_DRIVE = 4'b0001,
    CH_FAST  = 4'b0010,
    CH_SLOW  = 4'b0100,
    CH_IDLE  = 4'b1000
  } dhc_chop_e;
  typedef enum logic [2:0] {
    DM_SLOW  = 3'b001,
    DM_MIXED = 3'b010,
    DM_FAST  = 3'b100
  } dhc_decay_e;
endpackage : dhc_pkg

//--- bench/dhc_props_properties.sv
// Checker of bridge, fault and bus behaviour seen at the top ports
`timescale 1ns/10ps
`default_nettype none
module dhc_props
  import dhc_pkg::*;
#(
  parameter int unsigned OVC_CNT = 100
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        bridge_a_out_one_hi,
  input wire logic        bridge_a_out_one_lo,
  input wire logic        bridge_a_out_two_hi,
  input wire logic        bridge_a_out_two_lo,
  input wire logic        bridge_b_out_one_hi,
  input wire logic        bridge_b_out_one_lo,
  input wire logic        bridge_b_out_two_hi,
  input wire logic        bridge_b_out_two_lo,
  input wire logic        bridge_b_scale_lsb,
  input wire logic        bridge_b_scale_msb,
  input wire logic        current_limit_a,
  input wire logic        reset_low_input,
  input wire logic        sleep_low_input,
  input wire logic        thermal_shutdown_in,
  input wire logic        undervoltage_lockout_in,
  input wire logic        charge_pump_en,
  input wire logic        regulator_output_en,
  input wire logic        fault_flag_low_oe
);
  logic       a_off;
  logic       b_off;
  logic [7:0] lim_cnt_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bridge fully open
  assign a_off = !(bridge_a_out_one_hi | bridge_a_out_one_lo | bridge_a_out_two_hi | bridge_a_out_two_lo);
  assign b_off = !(bridge_b_out_one_hi | bridge_b_out_one_lo | bridge_b_out_two_hi | bridge_b_out_two_lo);
  // Cycles of bridge A current limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !current_limit_a || !reset_low_input || !sleep_low_input) begin
      lim_cnt_r <= 8'h00;
    end else if (lim_cnt_r != 8'hff) begin
      lim_cnt_r <= lim_cnt_r + 8'h01;
    end
  end
  sequence s_pump_off;
    !charge_pump_en && !regulator_output_en;
  endsequence
  property p_no_shoot;
    !(bridge_a_out_one_hi && bridge_a_out_one_lo) && !(bridge_a_out_two_hi && bridge_a_out_two_lo);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("leg A high and low together");
  property p_scale_off;
    (bridge_b_scale_lsb && bridge_b_scale_msb) [*5] |-> b_off;
  endproperty
  a_scale_off: assert property (p_scale_off) else $error("bridge B drives at scale off");
  property p_rst_pin;
    !reset_low_input [*5] |-> a_off && b_off;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("bridges drive in reset");
  property p_sleep;
    !sleep_low_input [*5] |-> s_pump_off ##0 (a_off && b_off);
  endproperty
  a_sleep: assert property (p_sleep) else $error("active while asleep");
  property p_wake;
    $rose(sleep_low_input) |=> (a_off && b_off) [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("drive too soon after wake");
  property p_uv;
    undervoltage_lockout_in [*5] |-> a_off && b_off;
  endproperty
  a_uv: assert property (p_uv) else $error("bridges drive at undervoltage");
  property p_therm;
    thermal_shutdown_in [*5] |-> fault_flag_low_oe && a_off && b_off;
  endproperty
  a_therm: assert property (p_therm) else $error("no shutdown on overtemperature");
  property p_ovc;
    32'(lim_cnt_r) >= OVC_CNT + 6 |-> fault_flag_low_oe && a_off;
  endproperty
  a_ovc: assert property (p_ovc) else $error("no overcurrent shutdown");
  property p_ovc_hold;
    $fell(current_limit_a) && fault_flag_low_oe && reset_low_input && sleep_low_input
      && !thermal_shutdown_in |=> fault_flag_low_oe [*4];
  endproperty
  a_ovc_hold: assert property (p_ovc_hold) else $error("overcurrent fault not latched");
  property p_rd_err;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > 10'h002 |=> s_axi_rvalid && s_axi_rresp == 2'h2;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
endmodule : dhc_props
bind dhc_top dhc_props #(.OVC_CNT(OVC_CNT)) u_props (.*);
`default_nettype wire

//--- bench/dhc_ctrl_model.sv
// Model of the external controller that drives bridge, reset and sleep pins
`timescale 1ns/10ps
`default_nettype none
module dhc_ctrl_model (
  input wire logic       aclk,
  input wire logic [1:0] cmd_a,
  input wire logic [1:0] cmd_b,
  input wire logic       pwm_en,
  input wire logic       run,
  input wire logic       awake,
  output logic           bridge_a_in_one,
  output logic           bridge_a_in_two,
  output logic           bridge_b_in_one,
  output logic           bridge_b_in_two,
  output logic           reset_low_input,
  output logic           sleep_low_input
);
  logic [3:0] tog_r = 4'h0;
  // Divider that paces the speed PWM
  always_ff @(posedge aclk) begin
    tog_r <= tog_r + 4'h1;
  end
  // Toggle the chosen bridge A input while the other stays low; bridge B inputs follow cmd_b untoggled
  always_ff @(posedge aclk) begin
    bridge_a_in_one <= cmd_a[1] & (!pwm_en | tog_r[3]);
    bridge_a_in_two <= cmd_a[0] & (!pwm_en | tog_r[3]);
    bridge_b_in_one <= cmd_b[1];
    bridge_b_in_two <= cmd_b[0];
    reset_low_input <= run;
    sleep_low_input <= awake;
  end
endmodule : dhc_ctrl_model
`default_nettype wire

//--- bench/dual_hbridge_chop_control_bench.sv
// Self-checking bench of the dual H-bridge chopping control
`timescale 1ns/10ps
`default_nettype none
module dual_hbridge_chop_control_bench;
  import dhc_pkg::*;
  localparam int unsigned WK = 20;
  localparam logic [3:0] DEC [4] = '{4'b0000, 4'b0110, 4'b1001, 4'b0101};
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb, oa, ob;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, cmd_a, cmd_b;
  logic [1:0] current_reference_a_sel, current_reference_b_sel;
  logic bridge_a_in_one, bridge_a_in_two, bridge_b_in_one, bridge_b_in_two;
  logic bridge_a_scale_lsb, bridge_a_scale_msb, bridge_b_scale_lsb, bridge_b_scale_msb;
  logic sense_node_a_trip, sense_node_b_trip, sense_node_a_zero, sense_node_b_zero;
  logic current_limit_a, current_limit_b, reset_low_input, sleep_low_input;
  logic decay_select_high, decay_select_low, thermal_shutdown_in, undervoltage_lockout_in;
  logic bridge_a_out_one_hi, bridge_a_out_one_lo, bridge_a_out_two_hi, bridge_a_out_two_lo;
  logic bridge_b_out_one_hi, bridge_b_out_one_lo, bridge_b_out_two_hi, bridge_b_out_two_lo;
  logic charge_pump_en, regulator_output_en, fault_flag_low_o, fault_flag_low_oe;
  logic pwm_en, run, awake;
  int err_count = 0;
  int tests_run = 0;
  int n;
  dhc_top #(.WAKE_CNT(WK), .OVC_CNT(5)) DUT (.*);
  dhc_ctrl_model u_ctrl (.*);
  assign oa = {bridge_a_out_one_hi, bridge_a_out_one_lo, bridge_a_out_two_hi, bridge_a_out_two_lo};
  assign ob = {bridge_b_out_one_hi, bridge_b_out_one_lo, bridge_b_out_two_hi, bridge_b_out_two_lo};
  // Clock of 20 ns
  always #10 aclk = ~aclk;
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge aclk);
  endtask : step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa = 1'b1;
    logic pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rchk
  task automatic wait_a(input logic [3:0] e, input int mx);
    n = 0;
    while (oa !== e && n < mx) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(oa), 32'(e));
  endtask : wait_a
  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    close_out();
  end
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} <= '0;
    {s_axi_wdata, bridge_a_scale_lsb, bridge_a_scale_msb, bridge_b_scale_lsb} <= '0;
    {bridge_b_scale_msb, sense_node_a_trip, sense_node_b_trip, sense_node_a_zero} <= '0;
    {sense_node_b_zero, current_limit_a, current_limit_b, decay_select_high} <= '0;
    {decay_select_low, thermal_shutdown_in, undervoltage_lockout_in, cmd_a, cmd_b} <= '0;
    {pwm_en, run, awake} <= '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} <= 6'h3f;
    step(10);
    aresetn <= 1'b1;
    run <= 1'b1;
    awake <= 1'b1;
    step(WK + 10);
    rchk(REG_CTRL, 32'hffff_ffff, CTRL_RST, RESP_OKAY);
    rchk(REG_STAT, 32'h0000_00f0, 32'h0000_0050, RESP_OKAY);
    rchk(12'h00c, 32'hffff_ffff, 32'h0000_0000, RESP_SLV);
    wr(12'h010, 32'h0000_0003, RESP_SLV);
    for (int c = 0; c < 4; c++) begin
      cmd_a <= 2'(c);
      cmd_b <= 2'(3 - c);
      step(6);
      chk(32'(oa), 32'(DEC[c]));
      chk(32'(ob), 32'(DEC[3 - c]));
      rchk(REG_DRIVE, 32'h0000_00ff, 32'({DEC[3 - c], DEC[c]}), RESP_OKAY);
    end
    cmd_a <= 2'b10;
    cmd_b <= 2'b10;
    wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
    wait_a(4'h0, 10);
    wr(REG_CTRL, CTRL_RST, RESP_OKAY);
    bridge_a_scale_lsb <= 1'b1;
    {bridge_b_scale_msb, bridge_b_scale_lsb} <= SCALE_OFF;
    wait_a(DEC[2], 1100);
    step(6);
    chk(32'(ob), 32'h0);
    chk(32'(current_reference_a_sel), 32'h1);
    chk(32'(current_reference_b_sel), 32'h3);
    {bridge_a_scale_lsb, bridge_b_scale_msb, bridge_b_scale_lsb} <= '0;
    decay_select_low <= 1'b1;
    step(4);
    rchk(REG_STAT, 32'h0000_00e0, 32'h0000_0020, RESP_OKAY);
    sense_node_a_trip <= 1'b1;
    wait_a(DEC[3], 1300);
    sense_node_a_trip <= 1'b0;
    wait_a(DEC[2], 1100);
    sense_node_a_trip <= 1'b1;
    wait_a(DEC[3], 300);
    chk(32'(n > BLANK_CYC - 10 && n < BLANK_CYC + 10), 32'h1);
    sense_node_a_trip <= 1'b0;
    decay_select_low <= 1'b0;
    decay_select_high <= 1'b1;
    wait_a(DEC[2], 1100);
    chk(32'(n > CHOP_CYC - BLANK_CYC - 12 && n < CHOP_CYC - BLANK_CYC + 12), 32'h1);
    rchk(REG_STAT, 32'h0000_00e0, 32'h0000_0080, RESP_OKAY);
    sense_node_a_trip <= 1'b1;
    wait_a(DEC[1], 300);
    sense_node_a_zero <= 1'b1;
    wait_a(4'h0, 10);
    {sense_node_a_zero, sense_node_a_trip, decay_select_high} <= '0;
    wait_a(DEC[2], 1100);
    sense_node_a_trip <= 1'b1;
    wait_a(DEC[1], 300);
    wait_a(DEC[3], 900);
    chk(32'(n > MIX_CYC - BLANK_CYC - 12 && n < MIX_CYC - BLANK_CYC + 12), 32'h1);
    sense_node_a_trip <= 1'b0;
    wait_a(DEC[2], 1100);
    current_limit_a <= 1'b1;
    step(12);
    current_limit_a <= 1'b0;
    step(8);
    chk(32'({fault_flag_low_oe, fault_flag_low_o, oa, ob}), 32'h209);
    rchk(REG_STAT, 32'h0000_0003, 32'h0000_0001, RESP_OKAY);
    run <= 1'b0;
    step(5);
    run <= 1'b1;
    wait_a(DEC[2], 1300);
    chk(32'(fault_flag_low_oe), 32'h0);
    thermal_shutdown_in <= 1'b1;
    step(6);
    chk(32'({fault_flag_low_oe, oa}), 32'h10);
    thermal_shutdown_in <= 1'b0;
    wait_a(DEC[2], 1300);
    undervoltage_lockout_in <= 1'b1;
    step(6);
    chk(32'({oa, ob}), 32'h0);
    undervoltage_lockout_in <= 1'b0;
    wait_a(DEC[2], 1300 + WK);
    awake <= 1'b0;
    step(6);
    chk(32'({charge_pump_en, regulator_output_en, oa}), 32'h0);
    awake <= 1'b1;
    wait_a(DEC[2], 1300 + WK);
    chk(32'({charge_pump_en, regulator_output_en}), 32'h3);
    pwm_en <= 1'b1;
    wait_a(4'h0, 60);
    wait_a(DEC[2], 60);
    close_out();
  end
endmodule : dual_hbridge_chop_control_bench
`default_nettype wire
